//--- design/pcg_top.sv
// Summary of operation
// - gate bit one clocks peripheral, zero stops it
// - access to unclocked peripheral answers bus fault
// - gate bits reset to zero unless noted
// - run, sleep, deep-sleep register per group
// - sleep registers only act with auto gating
// - group0 bit 6 hibernation, resets one in run, sleep and deep-sleep
// - group0 deep-sleep bit 3 watchdog gate
// - group0 bits 24, 20, 16 gate three units
// - group0 deep-sleep reserved bits read zero
// - group1 bit 4 gates sync serial unit
// - group1 bit 0 gates async serial unit
// - group1 bit 12 gates two-wire unit
// - group1 resets zero, reserved bits read zero
// - group1 run 0x104, sleep 0x114
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "pcg_regs.svh"

module pcg_top
   import pcg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire pcg_bus_type i_bus,
   input wire logic i_sleep,
   input wire logic i_deep_sleep,
   input wire pcg_acc_type i_acc,
   output logic [31:0] o_rdata,
   output logic [31:0] o_clk_en_g0,
   output logic [31:0] o_clk_en_g1,
   output logic o_bus_fault,
   output logic o_irq
);

   pcg_state_type st_reg;
   pcg_state_type st_next;
   logic ev_fault;
   logic ev_mode;
   logic acc_on;

   // picks the gate word that governs the current power mode
   function automatic logic [31:0] gate_sel(
      input pcg_mode_type m,
      input logic auto_on,
      input logic [31:0] r,
      input logic [31:0] s,
      input logic [31:0] d
   );
      logic [31:0] g;
      g = r;
      if (auto_on) begin
         case (m)
            pcg_mode_run: g = r;
            pcg_mode_sleep: g = s;
            pcg_mode_deep: g = d;
            default: g = r;
         endcase
      end
      return g;
   endfunction

   // keeps only implemented gate bits, reserved read zero
   function automatic logic [31:0] keep_bits(
      input logic [31:0] wd,
      input logic [31:0] msk
   );
      return wd & msk;
   endfunction

   // access check against the gates now delivered
   always_comb begin
      acc_on = i_acc.grp ? st_reg.en1[i_acc.idx] : st_reg.en0[i_acc.idx];
      o_bus_fault = i_acc.valid && !acc_on;
   end

   always_comb begin
      st_next = st_reg;
      st_next.rdata = 32'h00000000;
      ev_fault = o_bus_fault;
      ev_mode = 1'b0;
      if (i_bus.wr) begin
         case (i_bus.addr)
            `PCG_OFS_RUN0: st_next.run0 = keep_bits(i_bus.wdata, `PCG_G0_MASK);
            `PCG_OFS_SLP0: st_next.slp0 = keep_bits(i_bus.wdata, `PCG_G0_MASK);
            // can, pwm, converter, hibernation, watchdog
            `PCG_OFS_DSL0: begin
               st_next.dsl0 = keep_bits(i_bus.wdata, `PCG_G0_MASK);
            end
            // timers, two-wire, sync and async serial
            `PCG_OFS_RUN1: begin
               st_next.run1 = keep_bits(i_bus.wdata, `PCG_G1_MASK);
            end
            `PCG_OFS_SLP1: begin
               st_next.slp1 = keep_bits(i_bus.wdata, `PCG_G1_MASK);
            end
            `PCG_OFS_DSL1: st_next.dsl1 = keep_bits(i_bus.wdata, `PCG_G1_MASK);
            `PCG_OFS_CTRL: st_next.auto_gate = i_bus.wdata[`PCG_CTRL_AUTO];
            `PCG_OFS_STAT: begin
               st_next.stat = st_reg.stat & ~i_bus.wdata[`PCG_STAT_MODE:`PCG_STAT_FAULT];
            end
            `PCG_OFS_MASK: st_next.mask = i_bus.wdata[`PCG_STAT_MODE:`PCG_STAT_FAULT];
            default: ;
         endcase
      end
      if (i_bus.rd) begin
         case (i_bus.addr)
            `PCG_OFS_RUN0: st_next.rdata = st_reg.run0;
            `PCG_OFS_RUN1: st_next.rdata = st_reg.run1;
            `PCG_OFS_SLP0: st_next.rdata = st_reg.slp0;
            `PCG_OFS_SLP1: st_next.rdata = st_reg.slp1;
            `PCG_OFS_DSL0: st_next.rdata = st_reg.dsl0;
            `PCG_OFS_DSL1: st_next.rdata = st_reg.dsl1;
            `PCG_OFS_CTRL: st_next.rdata = {31'h00000000, st_reg.auto_gate};
            `PCG_OFS_ACT0: st_next.rdata = st_reg.en0;
            `PCG_OFS_ACT1: st_next.rdata = st_reg.en1;
            `PCG_OFS_STAT: st_next.rdata = {30'h00000000, st_reg.stat};
            `PCG_OFS_MASK: st_next.rdata = {30'h00000000, st_reg.mask};
            default: st_next.rdata = 32'h00000000;
         endcase
      end
      // deep sleep outranks sleep
      if (i_deep_sleep) begin
         st_next.mode = pcg_mode_deep;
      end else if (i_sleep) begin
         st_next.mode = pcg_mode_sleep;
      end else begin
         st_next.mode = pcg_mode_run;
      end
      ev_mode = st_next.mode != st_reg.mode;
      // a new event beats a clear in the same cycle
      st_next.stat = st_next.stat | {ev_mode, ev_fault};
      st_next.en0 = gate_sel(st_reg.mode, st_reg.auto_gate, st_reg.run0, st_reg.slp0,
         st_reg.dsl0);
      st_next.en1 = gate_sel(st_reg.mode, st_reg.auto_gate, st_reg.run1, st_reg.slp1,
         st_reg.dsl1);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg.run0 <= `PCG_G0_RST;
         st_reg.slp0 <= `PCG_G0_RST;
         st_reg.dsl0 <= `PCG_G0_RST;
         st_reg.run1 <= `PCG_G1_RST;
         st_reg.slp1 <= `PCG_G1_RST;
         st_reg.dsl1 <= `PCG_G1_RST;
         st_reg.auto_gate <= 1'b0;
         st_reg.mode <= pcg_mode_run;
         st_reg.stat <= 2'h0;
         st_reg.mask <= 2'h0;
         st_reg.en0 <= `PCG_G0_RST;
         st_reg.en1 <= `PCG_G1_RST;
         st_reg.rdata <= 32'h00000000;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rdata = st_reg.rdata;
   assign o_clk_en_g0 = st_reg.en0;
   assign o_clk_en_g1 = st_reg.en1;
   assign o_irq = |(st_reg.stat & st_reg.mask);

   // checks

   logic seen_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seen_reg <= 1'b0;
      end else begin
         seen_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking

   default disable iff (!i_rst_n);

   a_reset_gates: assert property (
      !seen_reg |-> (st_reg.run1 == 32'h00000000) && (st_reg.slp1 == 32'h00000000)
         && (o_clk_en_g1 == 32'h00000000))
      else $error("gates not cleared after reset");

   a_hibernate_reset: assert property (
      !seen_reg |-> st_reg.dsl0[`PCG_G0_HIBER] && o_clk_en_g0[`PCG_G0_HIBER]
         && !o_clk_en_g0[`PCG_G0_WDOG])
      else $error("hibernation gate not set after reset");

   a_run_follow: assert property (
      (!st_reg.auto_gate || st_reg.mode == pcg_mode_run) ##1 (!st_reg.auto_gate
         || st_reg.mode == pcg_mode_run)[*2] |-> o_clk_en_g1 == $past(st_reg.run1)
         && o_clk_en_g0 == $past(st_reg.run0))
      else $error("run gates not delivered");

   a_sleep_select: assert property (
      st_reg.auto_gate && st_reg.mode == pcg_mode_sleep |=> o_clk_en_g1 == $past(st_reg.slp1)
         && o_clk_en_g0 == $past(st_reg.slp0))
      else $error("sleep gates not applied");

   a_deep_select: assert property (
      st_reg.auto_gate && st_reg.mode == pcg_mode_deep |=> o_clk_en_g0 == $past(st_reg.dsl0)
         && o_clk_en_g1 == $past(st_reg.dsl1))
      else $error("deep-sleep gates not applied");

   a_fault_gated: assert property (
      i_acc.valid && !i_acc.grp && !o_clk_en_g0[i_acc.idx] |-> o_bus_fault
         ##1 st_reg.stat[`PCG_STAT_FAULT])
      else $error("unclocked access gave no fault");

   a_fault_clean: assert property (
      i_acc.valid && i_acc.grp && o_clk_en_g1[i_acc.idx] |-> !o_bus_fault)
      else $error("fault on clocked peripheral");

   a_rsvd_group0: assert property (
      (st_reg.dsl0 & ~`PCG_G0_MASK) == 32'h00000000)
      else $error("group0 reserved bits not zero");

   a_rsvd_group1: assert property (
      ((st_reg.run1 | st_reg.slp1) & ~`PCG_G1_MASK) == 32'h00000000)
      else $error("group1 reserved bits not zero");

   a_write_dsl0: assert property (
      i_bus.wr && i_bus.addr == `PCG_OFS_DSL0 |=>
         st_reg.dsl0[`PCG_G0_CANBUS] == $past(i_bus.wdata[`PCG_G0_CANBUS])
         && st_reg.dsl0[`PCG_G0_WDOG] == $past(i_bus.wdata[`PCG_G0_WDOG]))
      else $error("group0 deep-sleep write lost");

   a_write_run1: assert property (
      i_bus.wr && i_bus.addr == `PCG_OFS_RUN1 |=>
         st_reg.run1 == ($past(i_bus.wdata) & `PCG_G1_MASK))
      else $error("group1 run write lost");

   a_read_run1: assert property (
      i_bus.rd && i_bus.addr == `PCG_OFS_RUN1 && !i_bus.wr |=> o_rdata == $past(st_reg.run1))
      else $error("group1 run read wrong");

   a_read_slp1: assert property (
      i_bus.rd && i_bus.addr == `PCG_OFS_SLP1 |=> o_rdata == $past(st_reg.slp1))
      else $error("group1 sleep read wrong");

   a_timer_gate: assert property (
      !st_reg.auto_gate && st_reg.run1[`PCG_G1_TMR2] ##1 !st_reg.auto_gate |->
         o_clk_en_g1[`PCG_G1_TMR2])
      else $error("timer 2 gate not delivered");

   a_uart_twi: assert property (
      !st_reg.auto_gate && !st_reg.run1[`PCG_G1_ASY0] && !st_reg.run1[`PCG_G1_TWI0] |=>
         !o_clk_en_g1[`PCG_G1_ASY0] && !o_clk_en_g1[`PCG_G1_TWI0])
      else $error("serial gate on while cleared");

   a_set_wins: assert property (
      o_bus_fault && i_bus.wr && i_bus.addr == `PCG_OFS_STAT |=>
         st_reg.stat[`PCG_STAT_FAULT])
      else $error("fault event lost under clear");

   a_irq_level: assert property (
      o_bus_fault && st_reg.mask[`PCG_STAT_FAULT]
         && !(i_bus.wr && i_bus.addr == `PCG_OFS_MASK) |=> o_irq)
      else $error("interrupt not raised on fault");

   // register writes and reads

   a_write_slp1: assert property (
      i_bus.wr && i_bus.addr == `PCG_OFS_SLP1 |=>
         st_reg.slp1 == ($past(i_bus.wdata) & `PCG_G1_MASK))
      else $error("group1 sleep write lost");

   a_write_dsl1: assert property (
      i_bus.wr && i_bus.addr == `PCG_OFS_DSL1 |=>
         st_reg.dsl1 == ($past(i_bus.wdata) & `PCG_G1_MASK))
      else $error("group1 deep-sleep write lost");

   a_write_apart: assert property (
      i_bus.wr && i_bus.addr == `PCG_OFS_RUN1 |=>
         $stable(st_reg.slp1) && $stable(st_reg.dsl1))
      else $error("group1 run write touched other modes");

   a_ctrl_write: assert property (
      i_bus.wr && i_bus.addr == `PCG_OFS_CTRL |=>
         st_reg.auto_gate == $past(i_bus.wdata[`PCG_CTRL_AUTO]))
      else $error("auto gating write lost");

   a_mask_write: assert property (
      i_bus.wr && i_bus.addr == `PCG_OFS_MASK |=>
         st_reg.mask == $past(i_bus.wdata[`PCG_STAT_MODE:`PCG_STAT_FAULT]))
      else $error("mask write lost");

   a_read_dsl0: assert property (
      i_bus.rd && i_bus.addr == `PCG_OFS_DSL0 |=> o_rdata == $past(st_reg.dsl0))
      else $error("group0 deep-sleep read wrong");

   a_read_active: assert property (
      i_bus.rd && i_bus.addr == `PCG_OFS_ACT1 |=> o_rdata == $past(o_clk_en_g1))
      else $error("group1 active gates read wrong");

   a_read_idle: assert property (
      !i_bus.rd |=> o_rdata == 32'h00000000)
      else $error("read data held past its cycle");

   a_rsvd_other: assert property (
      ((st_reg.run0 | st_reg.slp0) & ~`PCG_G0_MASK) == 32'h00000000
         && (st_reg.dsl1 & ~`PCG_G1_MASK) == 32'h00000000)
      else $error("reserved gate bits not zero");

   // gate delivery

   a_enable_legal: assert property (
      (o_clk_en_g0 & ~`PCG_G0_MASK) == 32'h00000000
         && (o_clk_en_g1 & ~`PCG_G1_MASK) == 32'h00000000)
      else $error("clock enabled for a missing unit");

   a_wdog_off: assert property (
      !st_reg.auto_gate && !st_reg.run0[`PCG_G0_WDOG] |=>
         !o_clk_en_g0[`PCG_G0_WDOG])
      else $error("watchdog clocked while gated");

   a_sync_serial: assert property (
      !st_reg.auto_gate && st_reg.run1[`PCG_G1_SYNC0] |=>
         o_clk_en_g1[`PCG_G1_SYNC0])
      else $error("sync serial gate not delivered");

   a_timer_low: assert property (
      !st_reg.auto_gate |=> o_clk_en_g1[`PCG_G1_TMR1:`PCG_G1_TMR0]
         == $past(st_reg.run1[`PCG_G1_TMR1:`PCG_G1_TMR0]))
      else $error("timer 1 or 0 gate wrong");

   // faults and status

   a_fault_group1: assert property (
      i_acc.valid && i_acc.grp && !o_clk_en_g1[i_acc.idx] |-> o_bus_fault)
      else $error("unclocked group1 access gave no fault");

   a_wdog_fault: assert property (
      i_acc.valid && !i_acc.grp && i_acc.idx == 5'(`PCG_G0_WDOG)
         && !o_clk_en_g0[`PCG_G0_WDOG] |-> o_bus_fault)
      else $error("unclocked watchdog access gave no fault");

   a_mode_event: assert property (
      st_reg.mode != $past(st_reg.mode) |-> st_reg.stat[`PCG_STAT_MODE])
      else $error("mode change not flagged");

   a_stat_clear: assert property (
      i_bus.wr && i_bus.addr == `PCG_OFS_STAT && i_bus.wdata[`PCG_STAT_FAULT]
         && !o_bus_fault |=> !st_reg.stat[`PCG_STAT_FAULT])
      else $error("fault status not cleared");

   c_fault_seen: cover property (i_acc.valid && o_bus_fault);
   c_sleep_gate: cover property (st_reg.auto_gate && st_reg.mode == pcg_mode_sleep ##1
      o_clk_en_g1 != 32'h00000000);
   c_deep_gate: cover property (st_reg.auto_gate && st_reg.mode == pcg_mode_deep);
   c_irq_raised: cover property (!o_irq ##1 o_irq);

endmodule

//--- design/pcg_regs.svh
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

// register offsets, byte addresses
`define PCG_OFS_RUN0 12'h100
`define PCG_OFS_RUN1 12'h104
`define PCG_OFS_SLP0 12'h110
`define PCG_OFS_SLP1 12'h114
`define PCG_OFS_DSL0 12'h120
`define PCG_OFS_DSL1 12'h124
`define PCG_OFS_CTRL 12'h130
`define PCG_OFS_ACT0 12'h138
`define PCG_OFS_ACT1 12'h13C
`define PCG_OFS_STAT 12'h140
`define PCG_OFS_MASK 12'h144

// group 0 gate positions
`define PCG_G0_CANBUS 24
`define PCG_G0_PWM 20
`define PCG_G0_ADC0 16
`define PCG_G0_HIBER 6
`define PCG_G0_WDOG 3

// group 1 gate positions
`define PCG_G1_TMR2 18
`define PCG_G1_TMR1 17
`define PCG_G1_TMR0 16
`define PCG_G1_TWI0 12
`define PCG_G1_SYNC0 4
`define PCG_G1_ASY0 0

// writable bits and reset values
`define PCG_G0_MASK ((32'h00000001 << `PCG_G0_CANBUS) | (32'h00000001 << `PCG_G0_PWM) | \
   (32'h00000001 << `PCG_G0_ADC0) | (32'h00000001 << `PCG_G0_HIBER) | \
   (32'h00000001 << `PCG_G0_WDOG))
`define PCG_G1_MASK ((32'h00000001 << `PCG_G1_TMR2) | (32'h00000001 << `PCG_G1_TMR1) | \
   (32'h00000001 << `PCG_G1_TMR0) | (32'h00000001 << `PCG_G1_TWI0) | \
   (32'h00000001 << `PCG_G1_SYNC0) | (32'h00000001 << `PCG_G1_ASY0))
`define PCG_G0_RST (32'h00000001 << `PCG_G0_HIBER)
`define PCG_G1_RST 32'h00000000

// control and interrupt fields
`define PCG_CTRL_AUTO 0
`define PCG_STAT_FAULT 0
`define PCG_STAT_MODE 1

`endif

//--- design/pcg_pkg.sv
package pcg_pkg;

   typedef enum logic [2:0] {
      pcg_mode_run = 3'b001,
      pcg_mode_sleep = 3'b010,
      pcg_mode_deep = 3'b100
   } pcg_mode_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } pcg_bus_type;

   typedef struct packed {
      logic valid;
      logic grp;
      logic [4:0] idx;
   } pcg_acc_type;

   typedef struct packed {
      logic [31:0] run0;
      logic [31:0] slp0;
      logic [31:0] dsl0;
      logic [31:0] run1;
      logic [31:0] slp1;
      logic [31:0] dsl1;
      logic auto_gate;
      pcg_mode_type mode;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [31:0] en0;
      logic [31:0] en1;
      logic [31:0] rdata;
   } pcg_state_type;

endpackage

//--- bench/pcg_periph_model.sv
`timescale 1ns/10ps
module pcg_periph_model
   import pcg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_bus_fault,
   output pcg_acc_type o_acc
);
   initial o_acc = '0;

   // one access held for one cycle; fault taken at the edge that ends it
   task automatic probe(input logic grp, input logic [4:0] idx, output logic fault);
      @(posedge i_clk);
      o_acc <= '{valid: 1'b1, grp: grp, idx: idx};
      @(posedge i_clk);
      fault = i_bus_fault;
      o_acc <= '{valid: 1'b0, grp: ~grp, idx: ~idx};
   endtask
endmodule

//--- bench/peripheral_clock_gating_regs_test.sv
`timescale 1ns/10ps
module peripheral_clock_gating_regs_test
   import pcg_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   pcg_bus_type bus = '0;
   logic sleep = 1'b0;
   logic deep = 1'b0;
   pcg_acc_type acc;
   logic [31:0] rdata;
   logic [31:0] en0;
   logic [31:0] en1;
   logic fault;
   logic irq;
   logic [31:0] v;
   logic f;
   int fails = 0;
   int cmp_count = 0;
   logic [4:0] g1_idx [6] = '{5'h00, 5'h04, 5'h0C, 5'h10, 5'h11, 5'h12};

   always #2.5 clk = ~clk;

   pcg_top u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .i_sleep(sleep),
      .i_deep_sleep(deep), .i_acc(acc), .o_rdata(rdata), .o_clk_en_g0(en0),
      .o_clk_en_g1(en1), .o_bus_fault(fault), .o_irq(irq));

   pcg_periph_model u_model (.i_clk(clk), .i_bus_fault(fault), .o_acc(acc));

   task automatic final_report;
      if (fails == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      rd(a, v);
      chk(v, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic mode(input logic s, input logic d);
      @(posedge clk);
      sleep <= s;
      deep <= d;
      tick(3);
   endtask

   task automatic probe_chk(input logic grp, input logic [4:0] idx, input logic exp);
      u_model.probe(grp, idx, f);
      chk({31'h00000000, f}, {31'h00000000, exp});
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(12'h104, 32'h00000000);
      rdchk(12'h114, 32'h00000000);
      rdchk(12'h120, 32'h00000040);
      chk(en0, 32'h00000040);
      chk(en1, 32'h00000000);
      foreach (g1_idx[i]) probe_chk(1'b1, g1_idx[i], 1'b1);
      probe_chk(1'b0, 5'h03, 1'b1);
      probe_chk(1'b0, 5'h06, 1'b0);
      // all-ones writes keep only the gate bits
      wr(12'h104, 32'hFFFFFFFF);
      rdchk(12'h104, 32'h00071011);
      wr(12'h114, 32'hFFFFFFFF);
      rdchk(12'h114, 32'h00071011);
      wr(12'h120, 32'hFFFFFFFF);
      rdchk(12'h120, 32'h01110048);
      chk(en1, 32'h00071011);
      foreach (g1_idx[i]) probe_chk(1'b1, g1_idx[i], 1'b0);
      rd(12'h100, v);
      wr(12'h100, v | 32'h00000008);
      tick(1);
      probe_chk(1'b0, 5'h03, 1'b0);
      // fault event, masked, then unmasked, then cleared
      probe_chk(1'b0, 5'h10, 1'b1);
      tick(1);
      chk({31'h00000000, irq}, 32'h00000000);
      rdchk(12'h140, 32'h00000001);
      wr(12'h144, 32'h00000001);
      tick(1);
      chk({31'h00000000, irq}, 32'h00000001);
      wr(12'h140, 32'h00000003);
      tick(1);
      chk({31'h00000000, irq}, 32'h00000000);
      // power modes, auto gating off then on
      wr(12'h114, 32'h00001000);
      mode(1'b1, 1'b0);
      chk(en1, 32'h00071011);
      wr(12'h130, 32'h00000001);
      tick(1);
      chk(en1, 32'h00001000);
      mode(1'b1, 1'b1);
      chk(en0, 32'h01110048);
      chk(en1, 32'h00000000);
      mode(1'b0, 1'b0);
      chk(en1, 32'h00071011);
      rdchk(12'h1FC, 32'h00000000);
      rdchk(12'h13C, 32'h00071011);
      // fault event and status clear in one cycle: the event stays
      wr(12'h140, 32'h00000003);
      fork
         probe_chk(1'b0, 5'h10, 1'b1);
         wr(12'h140, 32'h00000001);
      join
      rdchk(12'h140, 32'h00000001);
      tick(1);
      chk(rdata, 32'h00000000);
      final_report;
   end

   initial begin
      #20000;
      fails++;
      final_report;
   end
endmodule
